/* hw/adc_seq_pkg.sv */
// Constants, register map and field layout of the A/D channel sequencer
// How it works
// - Conversions start from software command, internal clock, or external input edge.
// - With first equal to last, that one channel is converted again on every conversion.
// - First and last channel define the range; only those channels are sampled.
// - Single-ended: inputs are channels 0 to 15 against analog ground.
// - Differential: eight pairs, input n positive and input n+8 negative.
// - Sample mode: one trigger gives exactly one conversion.
// - Sample mode with a range: next channel per trigger, wrapping last to first.
// - Scan mode: one trigger converts every channel of the range once.
// - Scan conversions follow back to back as fast as the converter allows.
// - No simultaneous sampling; channels are converted one after another.
// - Input range chosen per channel from four unipolar and bipolar ranges.
// - Results are 16 bits; total conversion rate capped at converter maximum.
// - Results are buffered in a 2048-sample FIFO read by the host.
// - Threshold interrupt when FIFO fill reaches the programmed threshold.
// - Bipolar results are two's complement, -32768 to +32767.
// - Unipolar results are straight binary, 0 to 65535.
package adc_seq_pkg;
  // --------------------------------------------------------------------------
  // Register word addresses
  // --------------------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_RANGE = 3'h1;
  localparam logic [2:0] ADDR_CHAN = 3'h2;
  localparam logic [2:0] ADDR_DIV = 3'h3;
  localparam logic [2:0] ADDR_THRESH = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h5;
  localparam logic [2:0] ADDR_CMD = 3'h6;
  localparam logic [2:0] ADDR_DATA = 3'h7;
  // --------------------------------------------------------------------------
  // Fields
  // --------------------------------------------------------------------------
  localparam int CTRL_TRIG_LSB = 0;
  localparam int CTRL_SCAN_BIT = 2;
  localparam int CTRL_DIFF_BIT = 3;
  localparam int CTRL_EN_BIT = 4;
  localparam int CHAN_FIRST_LSB = 0;
  localparam int CHAN_LAST_LSB = 8;
  localparam int STAT_THR_BIT = 16;
  localparam int STAT_OVR_BIT = 17;
  localparam int STAT_OVF_BIT = 18;
  localparam int STAT_BUSY_BIT = 19;
  localparam int CMD_SWTRIG_BIT = 0;
  localparam int CMD_FLUSH_BIT = 1;
  localparam int RANGE_UNI_BIT = 1;
  localparam logic [1:0] TRIG_SW = 2'h0;
  localparam logic [1:0] TRIG_CLK = 2'h1;
  localparam logic [1:0] TRIG_EXT = 2'h2;
  // Range codes: 0 +/-5V, 1 +/-10V, 2 0-5V, 3 0-10V
  localparam logic [1:0] RANGE_BIP5 = 2'h0;
  localparam logic [1:0] RANGE_BIP10 = 2'h1;
  localparam logic [1:0] RANGE_UNI5 = 2'h2;
  localparam logic [1:0] RANGE_UNI10 = 2'h3;
  // --------------------------------------------------------------------------
  // Reset values and sizes
  // --------------------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RANGE_RST = 32'h0000_0000;
  localparam logic [31:0] CHAN_RST = 32'h0000_0000;
  localparam logic [31:0] DIV_RST = 32'h0000_03e8;
  localparam logic [31:0] THRESH_RST = 32'h0000_0000;
  localparam int SAMPLE_W = 16;
  localparam int NUM_CH = 16;
  localparam int FIFO_DEPTH = 2048;
  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_CONV_NS = 10000;
  localparam int MIN_CONV_CYCLES = (MIN_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum {ST_IDLE, ST_START, ST_WAIT} seqState_t;
endpackage

/* hw/adc_channel_sequencer.sv */
// A/D channel sequencer with trigger select, sample/scan modes and result FIFO
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
module adc_channel_sequencer #(
  parameter int DEPTH = adc_seq_pkg::FIFO_DEPTH,
  parameter int CONV_GAP = adc_seq_pkg::MIN_CONV_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic extTrigger,
  input wire logic adcDone,
  input wire logic [15:0] adcData,
  output logic adcStart,
  output logic [3:0] adcPosSel,
  output logic [3:0] adcNegSel,
  output logic adcNegGround,
  output logic [1:0] adcRange,
  output logic thresholdIrq
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // Refused at elaboration: pointers wrap by power of two, gap counter is 12 bits
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  if (CONV_GAP < 1 || CONV_GAP > 4096) $error("CONV_GAP out of range");

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // Round-robin step inside [first, last]
  function automatic logic [3:0] nextChannel(input logic [3:0] cur, input logic [3:0] first,
                                             input logic [3:0] last);
    return (cur >= last || cur < first) ? first : 4'(cur + 4'h1);
  endfunction

  // --------------------------------------------------------------------------
  // Registers and bus slave
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_q, rangeTab_q, chan_q, div_q, thresh_q;
  logic overrun_q, overflow_q, popOk_q;
  logic ack_q;
  logic [31:0] readData_q;
  logic [CW-1:0] count_q;
  logic [AW-1:0] wrPtr_q, rdPtr_q;
  logic [adc_seq_pkg::SAMPLE_W-1:0] mem [DEPTH];
  adc_seq_pkg::seqState_t state_q;

  logic reqActive, accept, wrAcc, rdAcc;
  logic swTrig, flush, clrOverrun, clrOverflow, pop, push;
  logic [1:0] trigSel;
  logic scanMode, diffMode, enabled;
  logic [3:0] firstCh, lastCh;
  logic [11:0] threshVal;
  logic fifoFull, fifoEmpty;

  assign reqActive = avs_read | avs_write;
  // One wait cycle: read data are registered before the answer
  assign avs_waitrequest = reqActive & ~ack_q;
  assign accept = reqActive & ack_q;
  assign wrAcc = accept & avs_write;
  assign rdAcc = accept & avs_read;
  assign avs_readdata = readData_q;

  assign trigSel = ctrl_q[adc_seq_pkg::CTRL_TRIG_LSB +: 2];
  assign scanMode = ctrl_q[adc_seq_pkg::CTRL_SCAN_BIT];
  assign diffMode = ctrl_q[adc_seq_pkg::CTRL_DIFF_BIT];
  assign enabled = ctrl_q[adc_seq_pkg::CTRL_EN_BIT];
  // Differential mode has only eight pair numbers
  assign firstCh = diffMode ? {1'b0, chan_q[adc_seq_pkg::CHAN_FIRST_LSB +: 3]}
                            : chan_q[adc_seq_pkg::CHAN_FIRST_LSB +: 4];
  assign lastCh = diffMode ? {1'b0, chan_q[adc_seq_pkg::CHAN_LAST_LSB +: 3]}
                           : chan_q[adc_seq_pkg::CHAN_LAST_LSB +: 4];
  assign threshVal = thresh_q[11:0];

  assign swTrig = wrAcc && avs_address == adc_seq_pkg::ADDR_CMD && avs_byteenable[0]
                  && avs_writedata[adc_seq_pkg::CMD_SWTRIG_BIT];
  assign flush = wrAcc && avs_address == adc_seq_pkg::ADDR_CMD && avs_byteenable[0]
                 && avs_writedata[adc_seq_pkg::CMD_FLUSH_BIT];
  assign clrOverrun = wrAcc && avs_address == adc_seq_pkg::ADDR_STATUS && avs_byteenable[2]
                      && avs_writedata[adc_seq_pkg::STAT_OVR_BIT];
  assign clrOverflow = wrAcc && avs_address == adc_seq_pkg::ADDR_STATUS && avs_byteenable[2]
                       && avs_writedata[adc_seq_pkg::STAT_OVF_BIT];
  assign pop = rdAcc && avs_address == adc_seq_pkg::ADDR_DATA && popOk_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) ack_q <= 1'b0;
    else ack_q <= reqActive & ~ack_q;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= adc_seq_pkg::CTRL_RST;
      rangeTab_q <= adc_seq_pkg::RANGE_RST;
      chan_q <= adc_seq_pkg::CHAN_RST;
      div_q <= adc_seq_pkg::DIV_RST;
      thresh_q <= adc_seq_pkg::THRESH_RST;
    end else if (wrAcc) begin
      case (avs_address)
        adc_seq_pkg::ADDR_CTRL: ctrl_q <= mergeBytes(ctrl_q, avs_writedata, avs_byteenable);
        adc_seq_pkg::ADDR_RANGE: begin
          rangeTab_q <= mergeBytes(rangeTab_q, avs_writedata, avs_byteenable);
        end
        adc_seq_pkg::ADDR_CHAN: chan_q <= mergeBytes(chan_q, avs_writedata, avs_byteenable);
        adc_seq_pkg::ADDR_DIV: div_q <= mergeBytes(div_q, avs_writedata, avs_byteenable);
        adc_seq_pkg::ADDR_THRESH: begin
          thresh_q <= mergeBytes(thresh_q, avs_writedata, avs_byteenable);
        end
        default: ;
      endcase
    end
  end

  // Pop only a word that was handed out; a push in the capture cycle must survive
  always_ff @(posedge clk_sys) begin
    if (sys_rst) popOk_q <= 1'b0;
    else if (avs_read && !ack_q) popOk_q <= avs_address == adc_seq_pkg::ADDR_DATA && !fifoEmpty;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) readData_q <= 32'h0000_0000;
    else if (avs_read && !ack_q) begin
      case (avs_address)
        adc_seq_pkg::ADDR_CTRL: readData_q <= ctrl_q;
        adc_seq_pkg::ADDR_RANGE: readData_q <= rangeTab_q;
        adc_seq_pkg::ADDR_CHAN: readData_q <= chan_q;
        adc_seq_pkg::ADDR_DIV: readData_q <= div_q;
        adc_seq_pkg::ADDR_THRESH: readData_q <= thresh_q;
        adc_seq_pkg::ADDR_STATUS: begin
          readData_q <= 32'h0000_0000;
          readData_q[CW-1:0] <= count_q;
          readData_q[adc_seq_pkg::STAT_THR_BIT] <= thresholdIrq;
          readData_q[adc_seq_pkg::STAT_OVR_BIT] <= overrun_q;
          readData_q[adc_seq_pkg::STAT_OVF_BIT] <= overflow_q;
          readData_q[adc_seq_pkg::STAT_BUSY_BIT] <= state_q != adc_seq_pkg::ST_IDLE;
        end
        adc_seq_pkg::ADDR_DATA: begin
          readData_q <= fifoEmpty ? 32'h0000_0000 : {16'h0000, mem[rdPtr_q]};
        end
        default: readData_q <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] extSync_q, doneSync_q;
  logic extPrev_q, donePrev_q;
  logic [15:0] dataMeta_q, dataSync_q;
  logic extEdge, doneEdge;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      extSync_q <= 2'h0;
      doneSync_q <= 2'h0;
      extPrev_q <= 1'b0;
      donePrev_q <= 1'b0;
      dataMeta_q <= 16'h0000;
      dataSync_q <= 16'h0000;
    end else begin
      extSync_q <= {extSync_q[0], extTrigger};
      doneSync_q <= {doneSync_q[0], adcDone};
      extPrev_q <= extSync_q[1];
      donePrev_q <= doneSync_q[1];
      dataMeta_q <= adcData;
      dataSync_q <= dataMeta_q;
    end
  end
  assign extEdge = extSync_q[1] & ~extPrev_q;
  assign doneEdge = doneSync_q[1] & ~donePrev_q;

  // --------------------------------------------------------------------------
  // Trigger sources
  // --------------------------------------------------------------------------
  logic [31:0] divCnt_q;
  logic clkTick, trigEvt;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) divCnt_q <= 32'h0000_0000;
    else if (!enabled || trigSel != adc_seq_pkg::TRIG_CLK || divCnt_q >= div_q)
      divCnt_q <= 32'h0000_0000;
    else divCnt_q <= divCnt_q + 32'h0000_0001;
  end
  assign clkTick = enabled && trigSel == adc_seq_pkg::TRIG_CLK && divCnt_q >= div_q;

  always_comb begin
    case (trigSel)
      adc_seq_pkg::TRIG_SW: trigEvt = enabled & swTrig;
      adc_seq_pkg::TRIG_CLK: trigEvt = clkTick;
      adc_seq_pkg::TRIG_EXT: trigEvt = enabled & extEdge;
      default: trigEvt = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  logic [3:0] curCh_q, nextCh_q;
  logic [11:0] gap_q;
  logic [15:0] pushData;
  logic lastOfScan;

  assign lastOfScan = !scanMode || curCh_q >= lastCh;
  assign push = state_q == adc_seq_pkg::ST_WAIT && doneEdge;
  // Converter code is offset binary; bipolar results flip the sign bit
  assign pushData = adcRange[adc_seq_pkg::RANGE_UNI_BIT] ? dataSync_q
                    : {~dataSync_q[15], dataSync_q[14:0]};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= adc_seq_pkg::ST_IDLE;
      curCh_q <= 4'h0;
      nextCh_q <= 4'h0;
    end else begin
      case (state_q)
        adc_seq_pkg::ST_IDLE: begin
          if (trigEvt) begin
            // Scan restarts at the first channel; rotation snaps into a changed range
            curCh_q <= (scanMode || nextCh_q < firstCh || nextCh_q > lastCh) ? firstCh
                       : nextCh_q;
            state_q <= adc_seq_pkg::ST_START;
          end
        end
        adc_seq_pkg::ST_START: begin
          if (fifoFull) state_q <= adc_seq_pkg::ST_IDLE;
          else if (gap_q == 12'h000) state_q <= adc_seq_pkg::ST_WAIT;
        end
        adc_seq_pkg::ST_WAIT: begin
          if (doneEdge) begin
            nextCh_q <= nextChannel(curCh_q, firstCh, lastCh);
            if (lastOfScan) state_q <= adc_seq_pkg::ST_IDLE;
            else begin
              curCh_q <= nextChannel(curCh_q, firstCh, lastCh);
              state_q <= adc_seq_pkg::ST_START;
            end
          end
        end
        default: state_q <= adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // Start spacing enforces the aggregate converter rate
  always_ff @(posedge clk_sys) begin
    if (sys_rst) gap_q <= 12'h000;
    else if (adcStart) gap_q <= 12'(CONV_GAP - 1);
    else if (gap_q != 12'h000) gap_q <= gap_q - 12'h001;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      adcStart <= 1'b0;
      adcPosSel <= 4'h0;
      adcNegSel <= 4'h0;
      adcNegGround <= 1'b1;
      adcRange <= adc_seq_pkg::RANGE_BIP5;
    end else begin
      adcStart <= state_q == adc_seq_pkg::ST_START && !fifoFull && gap_q == 12'h000 && !adcStart;
      if (state_q == adc_seq_pkg::ST_START && !adcStart) begin
        adcPosSel <= diffMode ? {1'b0, curCh_q[2:0]} : curCh_q;
        adcNegSel <= diffMode ? {1'b1, curCh_q[2:0]} : 4'h0;
        adcNegGround <= ~diffMode;
        adcRange <= rangeTab_q[2*curCh_q +: 2];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      overrun_q <= 1'b0;
      overflow_q <= 1'b0;
    end else begin
      // A new event wins over a clear in the same cycle
      overrun_q <= (overrun_q & ~clrOverrun)
                   | (trigEvt && state_q != adc_seq_pkg::ST_IDLE);
      overflow_q <= (overflow_q & ~clrOverflow)
                    | (state_q == adc_seq_pkg::ST_START && fifoFull);
    end
  end

  // --------------------------------------------------------------------------
  // Result FIFO
  // --------------------------------------------------------------------------
  assign fifoFull = count_q == CW'(DEPTH);
  assign fifoEmpty = count_q == '0;
  // Compared at full width so a threshold above the depth never wraps to a small value
  assign thresholdIrq = threshVal != 12'h000 && 32'(count_q) >= 32'(threshVal);

  always_ff @(posedge clk_sys) begin
    if (push) mem[wrPtr_q] <= pushData;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [12:0] since_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) since_q <= 13'h1fff;
    else if (adcStart) since_q <= 13'h0001;
    else if (since_q != 13'h1fff) since_q <= since_q + 13'h0001;
  end

  a_start_spacing: assert property (@(posedge clk_sys) disable iff (sys_rst)
    adcStart |-> since_q >= 13'(CONV_GAP)) else $error("conversion starts too close");
  a_chan_inside: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_q == adc_seq_pkg::ST_WAIT |-> curCh_q >= firstCh && curCh_q <= lastCh
    || firstCh > lastCh) else $error("channel outside range");
  a_diff_pair: assert property (@(posedge clk_sys) disable iff (sys_rst)
    adcStart && !adcNegGround |-> adcNegSel == adcPosSel + 4'h8) else $error("bad pair");
  a_se_ground: assert property (@(posedge clk_sys) disable iff (sys_rst)
    adcStart && !diffMode |-> adcNegGround) else $error("single-ended not grounded");
  a_overrun_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    trigEvt && state_q != adc_seq_pkg::ST_IDLE |=> overrun_q) else $error("overrun lost");
  a_full_holdoff: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fifoFull && state_q == adc_seq_pkg::ST_START |=> !adcStart && overflow_q)
    else $error("conversion while full");
  a_irq_reach: assert property (@(posedge clk_sys) disable iff (sys_rst)
    push && !pop && !flush && threshVal != 12'h000 && count_q + CW'(1) == CW'(threshVal)
    |=> thresholdIrq) else $error("threshold missed");
  a_sample_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
    push && !scanMode |=> state_q == adc_seq_pkg::ST_IDLE) else $error("extra conversion");
  a_bipolar_fmt: assert property (@(posedge clk_sys) disable iff (sys_rst)
    push && !adcRange[1] |-> pushData[15] != dataSync_q[15]) else $error("bipolar format");
  a_bus_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(reqActive) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus timing");
endmodule

/* tb/adc_conv_model.sv */
// Behavioural model of the external converter and its input multiplexers
module adc_conv_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic adcStart,
  input wire logic [3:0] adcPosSel,
  input wire logic [3:0] adcNegSel,
  input wire logic adcNegGround,
  input wire logic [1:0] adcRange,
  output logic adcDone,
  output logic [15:0] adcData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h00;
  logic [15:0] raw = 16'h0000;
  // Code names the mux setting, so a wrong channel shows up in the data
  always @(posedge clk_sys) begin
    if (adcStart) begin
      cnt <= slow ? 8'h28 : 8'h0a;
      raw <= {adcPosSel, adcNegGround ? 4'h0 : adcNegSel, adcNegGround, adcRange, 5'h15};
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  // Data valid only while done is high; otherwise the bus shows the inverse
  assign adcDone = (cnt != 8'h00) && (cnt <= 8'h06);
  assign adcData = adcDone ? raw : ~raw;
endmodule

/* tb/adc_channel_sequencer_tb.sv */
// Self-checking bench for the A/D channel sequencer
module adc_channel_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] pos; logic [3:0] neg; logic gnd; logic [1:0] rng;
    logic chkNeg;} sel_t;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, chkRd = 1'b0, extTrigger = 1'b0, slow = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rangeReg, rdData;
  logic avs_waitrequest, adcDone, adcStart, adcNegGround, thresholdIrq;
  logic [15:0] adcData;
  logic [3:0] adcPosSel, adcNegSel;
  logic [1:0] adcRange;
  int failures = 0;
  int cmpCount = 0;
  logic [31:0] rdQ[$];
  sel_t selQ[$];
  sel_t curSel;
  time t0;
  always #5 clk_sys = ~clk_sys;
  adc_channel_sequencer #(.DEPTH(16), .CONV_GAP(10)) adc_channel_sequencer_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .extTrigger(extTrigger),
    .adcDone(adcDone), .adcData(adcData), .adcStart(adcStart), .adcPosSel(adcPosSel),
    .adcNegSel(adcNegSel), .adcNegGround(adcNegGround), .adcRange(adcRange),
    .thresholdIrq(thresholdIrq));
  adc_conv_model adc_conv_model_inst (
    .clk_sys(clk_sys), .slow(slow), .adcStart(adcStart), .adcPosSel(adcPosSel),
    .adcNegSel(adcNegSel), .adcNegGround(adcNegGround), .adcRange(adcRange),
    .adcDone(adcDone), .adcData(adcData));
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic sel_t selOf(input int ch, input logic diff);
    sel_t s;
    s.pos = 4'(ch);
    s.neg = diff ? 4'(ch + 8) : 4'h0;
    s.gnd = ~diff;
    s.rng = rangeReg[2 * ch +: 2];
    s.chkNeg = diff;
    return s;
  endfunction
  // Bipolar codes come out two's complement, unipolar straight
  function automatic logic [31:0] expData(input sel_t s);
    return {16'h0000, {s.pos, s.neg, s.gnd, s.rng, 5'h15} ^ {~s.rng[1], 15'h0000}};
  endfunction
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    if (failures == 0 && cmpCount > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic busOp(input logic wr, input logic [2:0] a, input logic [31:0] d, input logic c);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    chkRd <= c;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdData = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    busOp(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    busOp(1'b0, a, 32'h0, 1'b1);
  endtask
  task automatic waitIdle();
    wait (selQ.size() == 0);
    do busOp(1'b0, adc_seq_pkg::ADDR_STATUS, 32'h0, 1'b0); while (rdData[19] !== 1'b0);
  endtask
  task automatic pulseExt();
    @(posedge clk_sys);
    extTrigger <= 1'b1;
    repeat (4) @(posedge clk_sys);
    extTrigger <= 1'b0;
  endtask
  // --------------------------------------------------------------------------
  // Monitor: every checked read and every start takes the oldest note
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (avs_read && !avs_waitrequest && chkRd) check("readdata", rdQ.pop_front(), avs_readdata);
    if (adcStart === 1'b1 && selQ.size() == 0) check("adcStart", 32'h0, 32'h1);
    if (adcStart === 1'b1 && selQ.size() != 0) begin
      curSel = selQ.pop_front();
      check("adcPosSel", 32'(curSel.pos), 32'(adcPosSel));
      check("adcNegGround", 32'(curSel.gnd), 32'(adcNegGround));
      check("adcRange", 32'(curSel.rng), 32'(adcRange));
      if (curSel.chkNeg) check("adcNegSel", 32'(curSel.neg), 32'(adcNegSel));
    end
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    results();
  end
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial begin
    rangeReg = lfsr(lfsr(32'h29));
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(adc_seq_pkg::ADDR_CTRL, adc_seq_pkg::CTRL_RST);
    rd(adc_seq_pkg::ADDR_DIV, adc_seq_pkg::DIV_RST);
    rd(adc_seq_pkg::ADDR_STATUS, 32'h0);
    rd(adc_seq_pkg::ADDR_CMD, 32'h0);
    wr(adc_seq_pkg::ADDR_RANGE, rangeReg);
    rd(adc_seq_pkg::ADDR_RANGE, rangeReg);
    // Sample mode, software trigger: round robin, then one channel repeated
    wr(adc_seq_pkg::ADDR_CTRL, 32'h10);
    for (int r = 0; r < 2; r++) begin
      wr(adc_seq_pkg::ADDR_CHAN, r == 0 ? 32'h0503 : 32'h0707);
      for (int i = 0; i < 4; i++) begin
        selQ.push_back(selOf(r == 0 ? 3 + i % 3 : 7, 1'b0));
        wr(adc_seq_pkg::ADDR_CMD, 32'h1);
        waitIdle();
      end
      for (int i = 0; i < 4; i++) rd(adc_seq_pkg::ADDR_DATA, expData(selOf(r == 0 ? 3 + i % 3 : 7, 1'b0)));
    end
    // Differential scan on an external edge, slow converter, trigger mid-scan
    slow <= 1'b1;
    wr(adc_seq_pkg::ADDR_CHAN, 32'h0301);
    wr(adc_seq_pkg::ADDR_CTRL, 32'h1e);
    for (int i = 1; i < 4; i++) selQ.push_back(selOf(i, 1'b1));
    pulseExt();
    wait (selQ.size() == 2);
    pulseExt();
    waitIdle();
    rd(adc_seq_pkg::ADDR_STATUS, 32'h0002_0003);
    wr(adc_seq_pkg::ADDR_STATUS, 32'h0002_0000);
    for (int i = 1; i < 4; i++) rd(adc_seq_pkg::ADDR_DATA, expData(selOf(i, 1'b1)));
    // Internal clock: starts one tick apart
    slow <= 1'b0;
    wr(adc_seq_pkg::ADDR_DIV, 32'd199);
    wr(adc_seq_pkg::ADDR_CHAN, 32'h0202);
    for (int i = 0; i < 3; i++) selQ.push_back(selOf(2, 1'b0));
    wr(adc_seq_pkg::ADDR_CTRL, 32'h11);
    wait (selQ.size() == 1);
    t0 = $time;
    wait (selQ.size() == 0);
    check("tickGap", 32'd2000, 32'($time - t0));
    wr(adc_seq_pkg::ADDR_CTRL, 32'h0);
    waitIdle();
    for (int i = 0; i < 3; i++) rd(adc_seq_pkg::ADDR_DATA, expData(selOf(2, 1'b0)));
    // Full scan fills the FIFO; one more trigger overflows
    wr(adc_seq_pkg::ADDR_THRESH, 32'h4);
    wr(adc_seq_pkg::ADDR_CHAN, 32'h0f00);
    wr(adc_seq_pkg::ADDR_CTRL, 32'h14);
    for (int i = 0; i < 16; i++) selQ.push_back(selOf(i, 1'b0));
    wr(adc_seq_pkg::ADDR_CMD, 32'h1);
    waitIdle();
    check("thresholdIrq", 32'h1, {31'h0, thresholdIrq});
    wr(adc_seq_pkg::ADDR_CMD, 32'h1);
    waitIdle();
    rd(adc_seq_pkg::ADDR_STATUS, 32'h0005_0010);
    for (int i = 0; i < 13; i++) rd(adc_seq_pkg::ADDR_DATA, expData(selOf(i, 1'b0)));
    @(negedge clk_sys);
    check("thresholdIrq", 32'h0, {31'h0, thresholdIrq});
    wr(adc_seq_pkg::ADDR_CMD, 32'h2);
    rd(adc_seq_pkg::ADDR_STATUS, 32'h0004_0000);
    rd(adc_seq_pkg::ADDR_DATA, 32'h0);
    results();
  end
endmodule
